// [rtl/imust_core.sv]
`timescale 1ns/10ps
`include "imust_defs.svh"
module imust_core #(
    parameter int unsigned CYC_PER_US = `IMUST_CLK_MHZ,
    parameter int unsigned BASE_US    = `IMUST_BASE_US,
    parameter int unsigned US_PER_MS  = 1000,
    parameter int unsigned SYNC_LAT_US = `IMUST_SYNC_LAT_US
) (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        sclk_in,
    input  wire logic        cs_n_in,
    input  wire logic        din_in,
    output logic             dout_out,
    input  wire logic [7:0]  sample_period_field_in,
    input  wire logic        sync_enable_in,
    input  wire logic        sync_clock_input_in,
    input  wire logic        sleep_req_in,
    input  wire logic        flash_test_req_in,
    input  wire logic        device_reset_req_in,
    input  wire logic [15:0] sample_data_in,
    output logic             sample_ready_out,
    output logic             data_ready_pin_out,
    output logic             low_power_out,
    output logic             data_valid_out,
    output logic             flash_busy_out
);
    typedef struct packed {
        imust_pkg::imust_state_t state;
        logic [31:0]             wait_us;
        logic [11:0]             us_div;
        logic [31:0]             sample_us;
        logic [31:0]             sync_us;
        logic                    sync_pend;
        logic [2:0]              sync_s;
        logic [4:0]              dr_cnt;
        logic [6:0]              addr;
        logic [15:0]             reply;
        logic [15:0]             result;
        logic                    booted;
        logic [31:0]             cs_low_us;
    } imust_core_st_t;
    imust_core_st_t       st_r;
    imust_core_st_t       st_nxt;
    logic                 low_power;
    logic [7:0]           prd;
    logic                 us_tick;
    logic                 sample_evt;
    logic                 cmd_valid;
    logic [15:0]          cmd_word;
    logic                 cs_low;
    imust_fifo_if #(.WIDTH(16)) fq ();

    // Zero is outside the accepted range and is treated as the fastest rate.
    assign prd       = (sample_period_field_in < `IMUST_PRD_MIN) ? 8'(`IMUST_PRD_MIN)
                                                                   : sample_period_field_in;
    assign low_power = prd > 8'(`IMUST_NORMAL_MAX_PRD);
    assign us_tick   = st_r.us_div == 12'(CYC_PER_US - 1);

    function automatic logic [31:0] ms_pick(input logic lp, input int unsigned n_ms, input int unsigned l_ms);
        return lp ? 32'(l_ms * US_PER_MS) : 32'(n_ms * US_PER_MS);
    endfunction

    imust_spi u_spi (
        .ref_clk_in    (ref_clk_in),
        .rst_n_in      (rst_n_in),
        .sclk_in       (sclk_in),
        .cs_n_in       (cs_n_in),
        .din_in        (din_in),
        .dout_out      (dout_out),
        .reply_in      (st_r.reply),
        .cmd_valid_out (cmd_valid),
        .cmd_word_out  (cmd_word),
        .cs_low_out    (cs_low)
    );

    imust_fifo #(.WIDTH(16), .DEPTH(`IMUST_FIFO_DEPTH)) u_fifo (
        .ref_clk_in (ref_clk_in),
        .rst_n_in   (rst_n_in),
        .port       (fq)
    );

    assign fq.in_valid  = sample_evt && (st_r.state == imust_pkg::IMUST_RUN);
    assign fq.in_data   = sample_data_in;
    // The FIFO drains into the output register only while chip select is high, not during a read or a wake.
    assign fq.out_ready = !cs_low;
    assign sample_ready_out = fq.in_ready;

    // Sample event: internal timebase or the delayed sync edge.
    assign sample_evt = sync_enable_in ? (st_r.sync_pend && st_r.sync_us == 32'(SYNC_LAT_US))
                                       : (us_tick && st_r.sample_us >= 32'(prd) * 32'(BASE_US) / 32'd1);

    always_comb begin
        st_nxt        = st_r;
        st_nxt.sync_s = {st_r.sync_s[1:0], sync_clock_input_in};
        st_nxt.us_div = us_tick ? 12'h000 : st_r.us_div + 12'h001;
        if (st_r.dr_cnt != 5'h00) begin
            st_nxt.dr_cnt = st_r.dr_cnt - 5'h01;
        end
        if (us_tick) begin
            st_nxt.sample_us = st_r.sample_us + 32'h1;
            if (st_r.wait_us != 32'h0) begin
                st_nxt.wait_us = st_r.wait_us - 32'h1;
            end
            if (st_r.sync_pend) begin
                st_nxt.sync_us = st_r.sync_us + 32'h1;
            end
            st_nxt.cs_low_us = cs_low ? st_r.cs_low_us + 32'h1 : 32'h0;
        end
        if (sample_evt) begin
            st_nxt.sample_us = 32'h0;
            st_nxt.sync_pend = 1'b0;
        end
        // No minimum-rate check: slow sync edges simply give slower samples.
        // A sync edge in the cycle of a sample wins, so that edge is not lost; an edge while one is pending restarts the wait.
        if (sync_enable_in && !st_r.sync_s[2] && st_r.sync_s[1]) begin
            st_nxt.sync_pend = 1'b1;
            st_nxt.sync_us   = 32'h0;
        end
        if (fq.out_valid && fq.out_ready) begin
            st_nxt.result = fq.out_data;
            st_nxt.dr_cnt = 5'(`IMUST_DR_PULSE_CYC);
        end
        if (cmd_valid && !cmd_word[`IMUST_WRITE_BIT]) begin
            st_nxt.addr  = cmd_word[`IMUST_ADDR_MSB:`IMUST_ADDR_LSB];
            st_nxt.reply = st_r.result;
        end
        unique case (st_r.state)
            imust_pkg::IMUST_BOOT: begin
                // The power-on wait is loaded on the first clock after reset, so RUN cannot come early.
                if (!st_r.booted) begin
                    st_nxt.booted  = 1'b1;
                    st_nxt.wait_us = ms_pick(low_power, `IMUST_POWERON_NORM_MS, `IMUST_POWERON_LP_MS);
                end else if (st_r.wait_us == 32'h0) begin
                    st_nxt.state = imust_pkg::IMUST_RUN;
                end
            end
            imust_pkg::IMUST_FLASH,
            imust_pkg::IMUST_WAKE: begin
                if (st_r.wait_us == 32'h0) begin
                    st_nxt.state = imust_pkg::IMUST_RUN;
                end
            end
            imust_pkg::IMUST_RUN: begin
                if (sleep_req_in) begin
                    st_nxt.state = imust_pkg::IMUST_SLEEP;
                end else if (flash_test_req_in) begin
                    st_nxt.state   = imust_pkg::IMUST_FLASH;
                    st_nxt.wait_us = ms_pick(low_power, `IMUST_FLASH_NORM_MS, `IMUST_FLASH_LP_MS);
                end
            end
            imust_pkg::IMUST_SLEEP: begin
                if (st_r.cs_low_us >= 32'(`IMUST_WAKE_US)) begin
                    st_nxt.state   = imust_pkg::IMUST_WAKE;
                    st_nxt.wait_us = ms_pick(low_power, `IMUST_SLEEP_NORM_MS, `IMUST_SLEEP_LP_MS);
                end
            end
            default: st_nxt.state = imust_pkg::IMUST_BOOT;
        endcase
        if (device_reset_req_in) begin
            st_nxt.state   = imust_pkg::IMUST_BOOT;
            st_nxt.wait_us = ms_pick(low_power, `IMUST_RESET_NORM_MS, `IMUST_RESET_LP_MS);
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '{state: imust_pkg::IMUST_BOOT, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign data_ready_pin_out = st_r.dr_cnt != 5'h00;
    assign low_power_out      = low_power;
    assign data_valid_out     = st_r.state == imust_pkg::IMUST_RUN;
    assign flash_busy_out     = st_r.state == imust_pkg::IMUST_FLASH;

    property p_mode;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (sample_period_field_in >= 8'h0A) |-> low_power_out;
    endproperty
    a_mode: assert property (p_mode) else $error("mode wrong");
    property p_dr;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (fq.out_valid && fq.out_ready) |=> data_ready_pin_out[*8];
    endproperty
    a_dr: assert property (p_dr) else $error("data ready short");
    property p_sleep_hold;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (st_r.state == imust_pkg::IMUST_SLEEP && !cs_low) |=> st_r.state != imust_pkg::IMUST_WAKE;
    endproperty
    a_sleep_hold: assert property (p_sleep_hold) else $error("woke without chip select");
    property p_flash;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (st_r.state == imust_pkg::IMUST_RUN && flash_test_req_in && !sleep_req_in && !device_reset_req_in)
        |=> flash_busy_out && st_r.wait_us != 32'h0;
    endproperty
    a_flash: assert property (p_flash) else $error("flash test not started");
    property p_reset;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        device_reset_req_in |=> !data_valid_out;
    endproperty
    a_reset: assert property (p_reset) else $error("reset did not stop data");
    property p_wake;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        $rose(st_r.state == imust_pkg::IMUST_WAKE) |-> st_r.wait_us >= 32'(`IMUST_SLEEP_NORM_MS * US_PER_MS);
    endproperty
    a_wake: assert property (p_wake) else $error("wake wait too short");
    property p_boot;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        !st_r.booted |=> !data_valid_out && st_r.wait_us != 32'h0;
    endproperty
    a_boot: assert property (p_boot) else $error("data before power-on wait");
    property p_sync;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        (sync_enable_in && st_r.sync_pend && st_r.sync_us < 32'(SYNC_LAT_US)) |-> !sample_evt;
    endproperty
    a_sync: assert property (p_sync) else $error("sync sample early");
endmodule // imust_core

// [rtl/imust_defs.svh]
// Behaviour
// - Sample period 0x09 or less means normal mode, 0x0A or more low power.
// - Serial port is SPI mode 3, 16-bit words, most significant bit first.
// - A read takes two words; contents return during the word after the address.
// - After each sample cycle, load results and pulse data ready high.
// - Data valid 180 ms after power-on in normal mode, 250 ms low power.
// - Data resumes 60 ms after reset in normal mode, 130 ms low power.
// - Data resumes 4 ms after sleep in normal mode, 9 ms low power.
// - Flash test completes in 17 ms normal mode, 90 ms low power.
// - Sample period accepts 0x01 to 0xFF, giving 3.21 to 819.2 samples per second.
// - With sync in use, data ready follows each sync edge after 600 us.
// - Sync rates 0.86 to 1.2 kHz accepted; slower rates still operate.
`ifndef IMUST_DEFS_SVH
`define IMUST_DEFS_SVH
`define IMUST_CLK_MHZ          100
`define IMUST_NORMAL_MAX_PRD   8'h09
`define IMUST_PRD_MIN          8'h01
`define IMUST_PRD_RESET        8'h01
`define IMUST_BASE_US          1221
`define IMUST_POWERON_NORM_MS  180
`define IMUST_POWERON_LP_MS    250
`define IMUST_RESET_NORM_MS    60
`define IMUST_RESET_LP_MS      130
`define IMUST_SLEEP_NORM_MS    4
`define IMUST_SLEEP_LP_MS      9
`define IMUST_FLASH_NORM_MS    17
`define IMUST_FLASH_LP_MS      90
`define IMUST_SYNC_LAT_US      600
`define IMUST_WAKE_US          20
`define IMUST_DR_PULSE_CYC     16
`define IMUST_WORD_BITS        16
`define IMUST_ADDR_MSB         14
`define IMUST_ADDR_LSB         8
`define IMUST_WRITE_BIT        15
`define IMUST_FIFO_DEPTH       16
`endif

// [rtl/imust_pkg.sv]
package imust_pkg;
    typedef enum logic [2:0] {
        IMUST_BOOT,
        IMUST_FLASH,
        IMUST_RUN,
        IMUST_SLEEP,
        IMUST_WAKE
    } imust_state_t;
    typedef logic [15:0] imust_word_t;
endpackage

// [rtl/imust_fifo_if.sv]
`timescale 1ns/10ps
interface imust_fifo_if #(parameter int WIDTH = 16);
    logic             in_valid;
    logic             in_ready;
    logic [WIDTH-1:0] in_data;
    logic             out_valid;
    logic             out_ready;
    logic [WIDTH-1:0] out_data;
    modport fifo (input in_valid, in_data, out_ready, output in_ready, out_valid, out_data);
    modport user (output in_valid, in_data, out_ready, input in_ready, out_valid, out_data);
endinterface // imust_fifo_if

// [rtl/imust_fifo.sv]
`timescale 1ns/10ps
module imust_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic    ref_clk_in,
    input  wire logic    rst_n_in,
    imust_fifo_if.fifo   port
);
    localparam int AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW-1:0] wr;
        logic [AW-1:0] rd;
        logic [AW:0]   count;
    } imust_fifo_st_t;
    imust_fifo_st_t   st_r;
    imust_fifo_st_t   st_nxt;
    logic [WIDTH-1:0] mem [DEPTH];
    logic             push;
    logic             pop;

    assign port.in_ready  = (st_r.count != (AW+1)'(DEPTH));
    assign port.out_valid = (st_r.count != '0);
    assign port.out_data  = mem[st_r.rd];
    assign push = port.in_valid && port.in_ready;
    assign pop  = port.out_valid && port.out_ready;

    always_comb begin
        st_nxt = st_r;
        if (push) begin
            st_nxt.wr = st_r.wr + 1'b1;
        end
        if (pop) begin
            st_nxt.rd = st_r.rd + 1'b1;
        end
        st_nxt.count = st_r.count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '0;
        end else begin
            st_r <= st_nxt;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (push) begin
            mem[st_r.wr] <= port.in_data;
        end
    end

    property p_count_bound;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        st_r.count <= (AW+1)'(DEPTH);
    endproperty
    a_count_bound: assert property (p_count_bound) else $error("fifo count above depth");
endmodule // imust_fifo

// [rtl/imust_spi.sv]
`timescale 1ns/10ps
`include "imust_defs.svh"
module imust_spi (
    input  wire logic        ref_clk_in,
    input  wire logic        rst_n_in,
    input  wire logic        sclk_in,
    input  wire logic        cs_n_in,
    input  wire logic        din_in,
    output logic             dout_out,
    input  wire logic [15:0] reply_in,
    output logic             cmd_valid_out,
    output logic [15:0]      cmd_word_out,
    output logic             cs_low_out
);
    typedef struct packed {
        logic [2:0]  sclk_s;
        logic [2:0]  cs_s;
        logic [2:0]  din_s;
        logic [15:0] shift_in;
        logic [15:0] shift_out;
        logic [4:0]  bits;
        logic        dout;
        logic        cmd_valid;
        logic [15:0] cmd_word;
    } imust_spi_st_t;
    imust_spi_st_t st_r;
    imust_spi_st_t st_nxt;
    logic          sclk_fall;
    logic          sclk_rise;
    logic          cs_low;

    // The first stage only absorbs metastability, so edges are judged on the second and third.
    function automatic logic sclk_edge_fall(input logic [1:0] s);
        return s[1] && !s[0];
    endfunction

    assign sclk_fall = sclk_edge_fall(st_r.sclk_s[2:1]);
    always_comb begin
        st_nxt           = st_r;
        st_nxt.cmd_valid = 1'b0;
        st_nxt.sclk_s    = {st_r.sclk_s[1:0], sclk_in};
        st_nxt.cs_s      = {st_r.cs_s[1:0], cs_n_in};
        st_nxt.din_s     = {st_r.din_s[1:0], din_in};
        if (cs_low) begin
            if (sclk_rise) begin
                st_nxt.shift_in = {st_r.shift_in[14:0], st_r.din_s[2]};
                st_nxt.bits     = st_r.bits + 5'h01;
                if (st_r.bits == 5'(`IMUST_WORD_BITS - 1)) begin
                    st_nxt.cmd_valid = 1'b1;
                    st_nxt.cmd_word  = {st_r.shift_in[14:0], st_r.din_s[2]};
                    st_nxt.bits      = 5'h00;
                end
            end
            if (sclk_fall) begin
                if (st_r.bits == 5'h00) begin
                    st_nxt.dout      = reply_in[15];
                    st_nxt.shift_out = {reply_in[14:0], 1'b0};
                end else begin
                    st_nxt.dout      = st_r.shift_out[15];
                    st_nxt.shift_out = {st_r.shift_out[14:0], 1'b0};
                end
            end
        end else begin
            st_nxt.bits = 5'h00;
        end
    end

    assign sclk_rise     = !st_r.sclk_s[2] && st_r.sclk_s[1];
    assign cs_low        = !st_r.cs_s[2] && !st_r.cs_s[1];
    assign dout_out      = st_r.dout;
    assign cmd_valid_out = st_r.cmd_valid;
    assign cmd_word_out  = st_r.cmd_word;
    assign cs_low_out    = cs_low;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            st_r <= '{sclk_s: 3'h7, cs_s: 3'h7, default: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    property p_word_count;
        @(posedge ref_clk_in) disable iff (!rst_n_in)
        st_r.cmd_valid |-> st_r.bits == 5'h00;
    endproperty
    a_word_count: assert property (p_word_count) else $error("word strobe without bit counter reset");
endmodule // imust_spi

// [verif/imust_spi_master.sv]
`timescale 1ns/10ps
// Behavioural SPI master; idle clock high, chip select high between frames.
module imust_spi_master #(
    // Slow against the core clock, so the synchroniser sees every serial clock edge.
    parameter real HALF_NS  = 62.5,
    parameter int  STALL_NS = 1000
) (
    input  wire logic dout_in,
    output logic      sclk_out,
    output logic      cs_n_out,
    output logic      din_out
);
    initial begin
        sclk_out = 1'b1;
        cs_n_out = 1'b1;
        din_out  = 1'b0;
    end
    // The 3 ns offset keeps every pin change away from the 100 MHz sampling edge.
    task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
        #3;
        cs_n_out = 1'b0;
        #100;
        for (int i = 15; i >= 0; i--) begin
            sclk_out = 1'b0;
            din_out  = tx[i];
            #(HALF_NS);
            sclk_out = 1'b1;
            rx[i]    = dout_in;
            #(HALF_NS);
        end
        #20;
        cs_n_out = 1'b1;
        // A released data line shows the inverse so no stale bit can pass for data.
        din_out  = ~din_out;
        // Stall is counted in simulation nanoseconds, 100 core clock cycles, enough for either mode.
        #(STALL_NS);
    endtask
    task automatic read(input logic [6:0] addr, output logic [15:0] data);
        logic [15:0] unused;
        xfer({1'b0, addr, 8'h00}, unused);
        xfer(16'h0000, data);
    endtask
    task automatic wake(input int ns);
        #3;
        cs_n_out = 1'b0;
        #(ns);
        cs_n_out = 1'b1;
    endtask
endmodule // imust_spi_master

// [verif/imust_core_tb.sv]
`timescale 1ns/10ps
// One core microsecond is one cycle and one millisecond ten, to keep the run short.
module imust_core_tb;
    localparam int MS = 10;
    logic        ref_clk_in, rst_n_in, sclk, cs_n, din, dout, sync_en, sync_clk;
    logic        sleep_req, flash_req, rst_req, smp_rdy, drdy, lp, valid, fbusy;
    logic [7:0]  prd;
    logic [15:0] smp, rd;
    int          errors, n_checks, cyc, t;
    imust_core #(.CYC_PER_US(1), .BASE_US(20), .US_PER_MS(MS), .SYNC_LAT_US(600)) dut (
        .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .sclk_in(sclk), .cs_n_in(cs_n),
        .din_in(din), .dout_out(dout), .sample_period_field_in(prd), .sync_enable_in(sync_en),
        .sync_clock_input_in(sync_clk), .sleep_req_in(sleep_req), .flash_test_req_in(flash_req),
        .device_reset_req_in(rst_req), .sample_data_in(smp), .sample_ready_out(smp_rdy),
        .data_ready_pin_out(drdy), .low_power_out(lp), .data_valid_out(valid),
        .flash_busy_out(fbusy));
    imust_spi_master m (.dout_in(dout), .sclk_out(sclk), .cs_n_out(cs_n), .din_out(din));
    initial begin
        ref_clk_in = 1'b0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            errors++;
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 60000) begin
            errors++;
            wrap_up();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk_in);
    endtask
    task automatic time_valid();
        t = 0;
        while (valid !== 1'b1 && t < 5000) begin
            tick(1);
            t++;
        end
    endtask
    task automatic t_power();
        time_valid();
        check("power_on_wait", 16'(t >= 179 * MS && t <= 181 * MS), 16'h0001);
        check("normal_mode", 16'(lp), 16'h0000);
    endtask
    task automatic t_modes();
        logic [7:0] p [5] = '{8'h00, 8'h01, 8'h09, 8'h0A, 8'hFF};
        for (int i = 0; i < 5; i++) begin
            prd <= p[i];
            tick(3);
            check("low_power", 16'(lp), 16'(i >= 3));
        end
        prd <= 8'h01;
        tick(3);
    endtask
    task automatic t_drdy();
        t = 0;
        while (drdy !== 1'b0 && t < 100) begin tick(1); t++; end
        while (drdy !== 1'b1 && t < 1000) begin tick(1); t++; end
        t = 0;
        while (drdy === 1'b1 && t < 100) begin tick(1); t++; end
        check("ready_pulse", 16'(t), 16'(`IMUST_DR_PULSE_CYC));
    endtask
    task automatic t_read();
        m.read(7'h0A, rd);
        check("read_word", rd, 16'hA5C3);
    endtask
    task automatic t_fill();
        // A frame held open stops the drain for far more than 16 sample periods.
        fork
            m.wake(8000);
            begin
                tick(790);
                check("buffer_full", 16'(smp_rdy), 16'h0000);
            end
        join
        tick(40);
        check("buffer_drained", 16'(smp_rdy), 16'h0001);
    endtask
    task automatic t_flash();
        for (int i = 0; i < 2; i++) begin
            prd <= i ? 8'h0A : 8'h01;
            tick(2);
            flash_req <= 1'b1;
            tick(1);
            flash_req <= 1'b0;
            tick(3);
            t = 3;
            while (fbusy === 1'b1 && t < 2000) begin tick(1); t++; end
            check("flash_time", 16'(t >= (i ? 90 : 17) * MS - 4 && t <= (i ? 90 : 17) * MS + 4), 16'h0001);
        end
    endtask
    task automatic t_reset();
        for (int i = 1; i >= 0; i--) begin
            prd <= i ? 8'h0A : 8'h01;
            tick(2);
            rst_req <= 1'b1;
            tick(1);
            rst_req <= 1'b0;
            tick(3);
            check("reset_drop", 16'(valid), 16'h0000);
            time_valid();
            t = t + 3;
            check("reset_wait", 16'(t >= (i ? 130 : 60) * MS - 4 && t <= (i ? 130 : 60) * MS + 4), 16'h0001);
        end
    endtask
    task automatic t_sleep();
        for (int i = 0; i < 2; i++) begin
            prd <= i ? 8'h0A : 8'h01;
            tick(2);
            sleep_req <= 1'b1;
            tick(1);
            sleep_req <= 1'b0;
            tick(20);
            check("asleep", 16'(valid), 16'h0000);
            fork
                m.wake(300);
                time_valid();
            join
            check("wake_time", 16'(t >= (i ? 9 : 4) * MS && t <= (i ? 9 : 4) * MS + 45), 16'h0001);
        end
        prd <= 8'h01;
    endtask
    task automatic t_sync();
        int per [3] = '{833, 2000, 833};
        sync_en <= 1'b1;
        tick(1000);
        for (int i = 0; i < 3; i++) begin
            while (drdy !== 1'b0) tick(1);
            sync_clk <= 1'b1;
            t = 0;
            while (drdy !== 1'b1 && t < 1000) begin
                tick(1);
                t++;
                if (t == 5) sync_clk <= 1'b0;
            end
            check("sync_latency", 16'(t >= 596 && t <= 606), 16'h0001);
            tick(per[i] - t);
        end
        sync_en <= 1'b0;
    endtask
    initial begin
        errors = 0;
        n_checks = 0;
        cyc = 0;
        rst_n_in = 1'b0;
        prd = 8'h01;
        sync_en = 1'b0;
        sync_clk = 1'b0;
        sleep_req = 1'b0;
        flash_req = 1'b0;
        rst_req = 1'b0;
        smp = 16'hA5C3;
        tick(5);
        rst_n_in <= 1'b1;
        t_power();
        t_modes();
        t_drdy();
        t_read();
        t_fill();
        t_flash();
        t_reset();
        t_sleep();
        t_sync();
        wrap_up();
    end
endmodule // imust_core_tb
